//--- design/adc_irq_and_input_select_regs.v
// Interrupt status, pin configuration and analog input select registers
// Operation
// - The interrupt register is 8 bits: top bit reads zero, three read-only flags, four writable control bits.
// - Bit 6 reads 1 while the result is stale since the last read or reset and 0 once a new result is ready.
// - Bit 5 reads 1 while no configuration checksum error exists and 0 once one has occurred.
// - Bit 4 resets to 1 and reads 0 when a power-on event occurred since the flag was last read.
// - With bit 3 clear all interrupts go to the shared pin; with it set the pin carries the bitstream plus few interrupts.
// - Bit 2 set drives the inactive pin level high; clear, the default, leaves it floating for a pull-up.
// - Bit 1, set after reset, lets fast commands through; clear rejects them.
// - Bit 0, set after reset, raises an interrupt at each conversion start; clear suppresses it.
// - With bit 3 set the modulator codes also appear through the conversion result register.
// - The input select register at 0x6 holds positive select in bits 7-4 and negative in 3-0, reset to 0 and 1.
// - Selector codes 0-7 pick channels, 8 ground, 9 supply, 10 reserved, higher ones references, diodes and 15 mid-supply.
`timescale 1ns/100ps
`default_nettype none
`include "adc_regs_map.vh"
module adc_irq_and_input_select_regs #(
  parameter SEL_W = 4
) (
  // Clock and reset
  input wire clock,
  input wire arst_n,
  // Register port from the serial command decoder
  input wire [`ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata,
  output reg reg_rdata_valid,
  // Events from conversion, checksum and power-on logic
  input wire new_result,
  input wire conv_start,
  input wire checksum_error,
  input wire por_event,
  input wire modulator_bitstream,
  // Fast command gate
  input wire fast_cmd_req,
  output reg fast_cmd_accept,
  output reg fast_command_enable,
  // Shared interrupt / bitstream pin
  output reg irq_pin_out,
  output reg irq_pin_oe_n,
  // Result register source select
  output reg result_shows_modulator,
  // Analog multiplexer selects
  output reg [SEL_W-1:0] positive_input_selector,
  output reg [SEL_W-1:0] negative_input_selector,
  output wire [(1<<SEL_W)-1:0] positive_select_onehot,
  output wire [(1<<SEL_W)-1:0] negative_select_onehot,
  output wire positive_code_reserved,
  output wire negative_code_reserved
);
  reg result_pending_flag;
  reg config_checksum_error_flag;
  reg no_por_flag;
  reg [3:0] ctrl;
  reg start_irq;
  wire wr_irq;
  wire wr_sel;
  wire rd_irq;
  wire rd_result;
  wire [7:0] irq_value;
  wire all_irq;
  wire few_irq;
  wire pin_active;
  wire data_ready_irq;
  wire checksum_irq;
  wire por_irq;
  reg [7:0] next_rdata;
  reg next_pin_out;
  reg next_pin_oe_n;

  // Access decode
  assign wr_irq = reg_write && (reg_addr == `OFF_IRQ_CFG);
  assign wr_sel = reg_write && (reg_addr == `OFF_INPUT_SEL);
  assign rd_irq = reg_read && (reg_addr == `OFF_IRQ_CFG);
  assign rd_result = reg_read && (reg_addr == `OFF_RESULT);

  // Interrupt register image, top bit held at zero
  assign irq_value = {1'b0, result_pending_flag, config_checksum_error_flag, no_por_flag, ctrl};

  // Status flags; a new event in the same cycle as the read wins
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      result_pending_flag <= `RST_RESULT_PENDING;
      config_checksum_error_flag <= `RST_CHECKSUM_OK;
      no_por_flag <= `RST_NO_POR;
    end else begin
      if (new_result) begin
        result_pending_flag <= 1'b0;
      end else if (rd_result) begin
        result_pending_flag <= 1'b1;
      end
      if (checksum_error) begin
        config_checksum_error_flag <= 1'b0;
      end
      if (por_event) begin
        no_por_flag <= 1'b0;
      end else if (rd_irq) begin
        no_por_flag <= 1'b1;
      end
    end
  end

  // Writable control bits and input selectors
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= `RST_CTRL;
      positive_input_selector <= `RST_POS_SEL;
      negative_input_selector <= `RST_NEG_SEL;
    end else begin
      if (wr_irq) begin
        ctrl <= reg_wdata[3:0];
      end
      if (wr_sel) begin
        positive_input_selector <= reg_wdata[7:4];
        negative_input_selector <= reg_wdata[3:0];
      end
    end
  end

  // Read data mux, unmapped offsets and the result offset answer zero
  always @* begin
    next_rdata = 8'h00;
    case (reg_addr)
      `OFF_IRQ_CFG: begin
        next_rdata = irq_value;
      end
      `OFF_INPUT_SEL: begin
        next_rdata = {positive_input_selector, negative_input_selector};
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // Read data register, held until the next read
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
      reg_rdata_valid <= 1'b0;
    end else begin
      reg_rdata_valid <= reg_read;
      if (reg_read) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // Interrupt sources, all active high here; the pin itself is active low
  assign data_ready_irq = !result_pending_flag;
  assign checksum_irq = !config_checksum_error_flag;
  assign por_irq = !no_por_flag;
  assign all_irq = data_ready_irq || start_irq || checksum_irq || por_irq;
  assign few_irq = checksum_irq || por_irq;
  assign pin_active = ctrl[`BIT_PIN_MODULATOR] ? few_irq : all_irq;

  // Conversion start pulse, gated by its enable
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      start_irq <= 1'b0;
    end else begin
      start_irq <= conv_start && ctrl[`BIT_START_IRQ_EN];
    end
  end

  // Next pin level: an active interrupt pulls low, else bitstream or the inactive level
  always @* begin
    next_pin_out = 1'b1;
    next_pin_oe_n = 1'b1;
    if (pin_active) begin
      next_pin_out = 1'b0;
      next_pin_oe_n = 1'b0;
    end else if (ctrl[`BIT_PIN_MODULATOR]) begin
      next_pin_out = modulator_bitstream;
      next_pin_oe_n = 1'b0;
    end else begin
      next_pin_out = 1'b1;
      next_pin_oe_n = !ctrl[`BIT_PIN_PUSH_PULL];
    end
  end

  // Shared pin drive and mode outputs, registered so the pin never glitches
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq_pin_out <= 1'b1;
      irq_pin_oe_n <= 1'b1;
      fast_command_enable <= 1'b1;
      fast_cmd_accept <= 1'b0;
      result_shows_modulator <= 1'b0;
    end else begin
      irq_pin_out <= next_pin_out;
      irq_pin_oe_n <= next_pin_oe_n;
      fast_command_enable <= ctrl[`BIT_FAST_CMD_EN];
      fast_cmd_accept <= fast_cmd_req && ctrl[`BIT_FAST_CMD_EN];
      result_shows_modulator <= ctrl[`BIT_PIN_MODULATOR];
    end
  end

  // Selector decoders for both multiplexer inputs
  input_select_decoder #(
    .CODE_W(SEL_W)
  ) u_pos_dec (
    .clock(clock),
    .arst_n(arst_n),
    .code(positive_input_selector),
    .select_onehot(positive_select_onehot),
    .code_reserved(positive_code_reserved),
    .select_is_channel()
  );

  input_select_decoder #(
    .CODE_W(SEL_W)
  ) u_neg_dec (
    .clock(clock),
    .arst_n(arst_n),
    .code(negative_input_selector),
    .select_onehot(negative_select_onehot),
    .code_reserved(negative_code_reserved),
    .select_is_channel()
  );
endmodule
`default_nettype wire

//--- design/adc_regs_map.vh
// Register offsets, field positions and reset values of the interrupt and input select registers
`ifndef ADC_REGS_MAP_VH
`define ADC_REGS_MAP_VH
`define ADDR_W 4
`define OFF_RESULT 4'h0
`define OFF_IRQ_CFG 4'h5
`define OFF_INPUT_SEL 4'h6
`define BIT_UNUSED 7
`define BIT_RESULT_PENDING 6
`define BIT_CHECKSUM_OK 5
`define BIT_NO_POR 4
`define BIT_PIN_MODULATOR 3
`define BIT_PIN_PUSH_PULL 2
`define BIT_FAST_CMD_EN 1
`define BIT_START_IRQ_EN 0
`define CTRL_MASK 8'h0f
`define RST_RESULT_PENDING 1'b1
`define RST_CHECKSUM_OK 1'b1
`define RST_NO_POR 1'b1
`define RST_CTRL 4'h3
`define RST_POS_SEL 4'h0
`define RST_NEG_SEL 4'h1
`define SEL_AGND 4'h8
`define SEL_AVDD 4'h9
`define SEL_RESERVED 4'ha
`define SEL_VCM 4'hf
`endif

//--- design/input_select_decoder.v
// One analog multiplexer selector: 4-bit code to registered one-hot select
`timescale 1ns/100ps
`default_nettype none
`include "adc_regs_map.vh"
module input_select_decoder #(
  parameter CODE_W = 4
) (
  // Clock and reset
  input wire clock,
  input wire arst_n,
  // Selector code
  input wire [CODE_W-1:0] code,
  // Decoded select
  output reg [(1<<CODE_W)-1:0] select_onehot,
  output reg code_reserved,
  output reg select_is_channel
);
  // Register the one-hot decode so the analog switches see clean levels
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      select_onehot <= {(1<<CODE_W){1'b0}};
      code_reserved <= 1'b0;
      select_is_channel <= 1'b0;
    end else begin
      select_onehot <= {{((1<<CODE_W)-1){1'b0}}, 1'b1} << code;
      code_reserved <= (code == `SEL_RESERVED);
      select_is_channel <= (code < `SEL_AGND);
    end
  end
endmodule
`default_nettype wire

//--- tb/host_model.sv
// Host register-port model
`timescale 1ns/100ps
`default_nettype none
module host_model (
  // Clock
  input wire logic clock,
  // Register port
  output logic [3:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_write,
  output logic reg_read,
  input wire logic [7:0] reg_rdata
);
  // Eight-channel part: every selector code except the reserved code 10 is connected
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end
  // Write, then an idle cycle; released lines show inverted data
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_write = 1'b1;
    @(posedge clock);
    #1;
    reg_write = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~v;
    @(posedge clock);
    #1;
  endtask
  // Read; data stands just after the edge that samples the read
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    reg_addr = a;
    reg_read = 1'b1;
    @(posedge clock);
    #1;
    reg_read = 1'b0;
    reg_addr = ~a;
    v = reg_rdata;
    @(posedge clock);
    #1;
  endtask
endmodule
`default_nettype wire

//--- tb/adc_irq_and_input_select_regs_properties.sv
// Port checks of the interrupt and input select registers
`timescale 1ns/100ps
`default_nettype none
module adc_regs_props (
  // Watched ports
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [3:0] reg_addr,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rdata_valid,
  input wire logic new_result,
  input wire logic checksum_error,
  input wire logic por_event,
  input wire logic fast_cmd_req,
  input wire logic fast_cmd_accept,
  input wire logic irq_pin_out,
  input wire logic irq_pin_oe_n,
  input wire logic result_shows_modulator,
  input wire logic [3:0] positive_input_selector,
  input wire logic [15:0] positive_select_onehot
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_read_answer: assert property (reg_read |=> reg_rdata_valid)
    else $error("no read answer");
  a_top_zero: assert property (reg_read && reg_addr == 4'h5 |=> !reg_rdata[7])
    else $error("top bit set");
  a_pending_clear: assert property (new_result ##1 reg_read && reg_addr == 4'h5 |=> !reg_rdata[6])
    else $error("pending flag");
  a_error_flag: assert property (checksum_error ##1 reg_read && reg_addr == 4'h5 |=> !reg_rdata[5])
    else $error("checksum flag");
  a_por_flag: assert property (por_event ##1 reg_read && reg_addr == 4'h5 |=> !reg_rdata[4])
    else $error("power-on flag");
  a_fast_cause: assert property (fast_cmd_accept |-> $past(fast_cmd_req))
    else $error("accept without request");
  a_mod_drive: assert property (result_shows_modulator |-> !irq_pin_oe_n)
    else $error("pin not driven");
  a_float_high: assert property (irq_pin_oe_n |-> irq_pin_out)
    else $error("floating pin low");
  a_onehot_code: assert property ($past(arst_n) |-> positive_select_onehot == 16'h1 << $past(positive_input_selector))
    else $error("one-hot mismatch");
endmodule
bind adc_irq_and_input_select_regs adc_regs_props props (
  .clock(clock),
  .arst_n(arst_n),
  .reg_addr(reg_addr),
  .reg_read(reg_read),
  .reg_rdata(reg_rdata),
  .reg_rdata_valid(reg_rdata_valid),
  .new_result(new_result),
  .checksum_error(checksum_error),
  .por_event(por_event),
  .fast_cmd_req(fast_cmd_req),
  .fast_cmd_accept(fast_cmd_accept),
  .irq_pin_out(irq_pin_out),
  .irq_pin_oe_n(irq_pin_oe_n),
  .result_shows_modulator(result_shows_modulator),
  .positive_input_selector(positive_input_selector),
  .positive_select_onehot(positive_select_onehot)
);
`default_nettype wire

//--- tb/adc_irq_and_input_select_regs_bench.sv
// Self-checking bench for the interrupt and input select registers
`timescale 1ns/100ps
`default_nettype none
module adc_irq_and_input_select_regs_bench;
  logic clock, arst_n, reg_write, reg_read, reg_rdata_valid, new_result, conv_start, checksum_error, por_event;
  logic modulator_bitstream, fast_cmd_req, fast_cmd_accept, fast_command_enable, irq_pin_out, irq_pin_oe_n;
  logic result_shows_modulator, positive_code_reserved, negative_code_reserved;
  logic [3:0] reg_addr, positive_input_selector, negative_input_selector;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic [15:0] positive_select_onehot, negative_select_onehot;
  int failures, checked;
  adc_irq_and_input_select_regs uut (.*);
  host_model host (.*);
  // Clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic t_reset;
    host.rd(4'h5, d);
    chk(d, 8'h73);
    host.rd(4'h6, d);
    chk(d, 8'h01);
    chk(irq_pin_oe_n, 1);
    $display("reset values done");
  endtask
  task automatic t_write;
    host.wr(4'h5, 8'hff);
    host.rd(4'h5, d);
    chk(d, 8'h7f);
    chk({result_shows_modulator, irq_pin_oe_n}, 2'b10);
    modulator_bitstream = 1'b1;
    cyc(1);
    chk(irq_pin_out, 1);
    modulator_bitstream = 1'b0;
    cyc(1);
    chk(irq_pin_out, 0);
    host.wr(4'h5, 8'h05);
    chk({irq_pin_oe_n, irq_pin_out}, 2'b01);
    chk(fast_command_enable, 0);
    fast_cmd_req = 1'b1;
    cyc(1);
    fast_cmd_req = 1'b0;
    chk(fast_cmd_accept, 0);
    conv_start = 1'b1;
    cyc(1);
    conv_start = 1'b0;
    cyc(1);
    chk(irq_pin_out, 0);
    cyc(1);
    chk(irq_pin_out, 1);
    host.wr(4'h5, 8'h02);
    chk(irq_pin_oe_n, 1);
    chk(fast_command_enable, 1);
    fast_cmd_req = 1'b1;
    conv_start = 1'b1;
    cyc(1);
    {fast_cmd_req, conv_start} = 2'b00;
    chk(fast_cmd_accept, 1);
    cyc(1);
    chk({irq_pin_oe_n, irq_pin_out}, 2'b11);
    $display("control bits done");
  endtask
  task automatic t_mux;
    for (int c = 0; c < 16; c++) begin
      host.wr(4'h6, {c[3:0], ~c[3:0]});
      host.rd(4'h6, d);
      chk(d, {c[3:0], ~c[3:0]});
      chk(negative_select_onehot, 16'h1 << (15 - c));
      chk({positive_input_selector, negative_input_selector}, {c[3:0], ~c[3:0]});
      chk(positive_select_onehot, 16'h1 << c);
      chk({positive_code_reserved, negative_code_reserved}, {c == 10, c == 5});
    end
    $display("input select done");
  endtask
  task automatic t_flags;
    {new_result, checksum_error, por_event} = 3'b111;
    cyc(1);
    {new_result, checksum_error, por_event} = 3'b000;
    host.rd(4'h5, d);
    chk(d, 8'h02);
    chk({irq_pin_oe_n, irq_pin_out}, 2'b00);
    host.rd(4'h0, d);
    chk(d, 8'h00);
    host.rd(4'h5, d);
    chk(d, 8'h52);
    $display("status flags done");
  endtask
  // Modulator mode keeps only the restricted interrupts on the pin
  task automatic t_modirq;
    modulator_bitstream = 1'b1;
    new_result = 1'b1;
    cyc(1);
    new_result = 1'b0;
    host.wr(4'h5, 8'h08);
    chk({irq_pin_oe_n, irq_pin_out}, 2'b01);
    por_event = 1'b1;
    cyc(1);
    por_event = 1'b0;
    cyc(1);
    chk({irq_pin_oe_n, irq_pin_out}, 2'b00);
    $display("modulator pin interrupts done");
  endtask
  // Watchdog
  initial begin
    repeat (2000) @(posedge clock);
    failures++;
    stop_test;
  end
  initial begin
    {new_result, conv_start, checksum_error, por_event, modulator_bitstream, fast_cmd_req} = 6'h00;
    failures = 0;
    checked = 0;
    arst_n = 1'b0;
    repeat (10) @(posedge clock);
    #1 arst_n = 1'b1;
    t_reset;
    t_write;
    t_mux;
    t_flags;
    arst_n = 1'b0;
    cyc(2);
    arst_n = 1'b1;
    t_reset;
    t_modirq;
    stop_test;
  end
endmodule
`default_nettype wire
